// ### flash_host_pkg.sv
// constants for the flash programming host and its bus-cycle engine
package flash_host_pkg;
   localparam int CLK_NS = 50;
   // command codes written to the device's command latch
   localparam logic [7:0] CODE_READ = 8'h00;
   localparam logic [7:0] CODE_IDENT = 8'h90;
   localparam logic [7:0] CODE_ERASE = 8'h20;
   localparam logic [7:0] CODE_ERASE_CHECK = 8'hA0;
   localparam logic [7:0] CODE_PROG_SETUP = 8'h40;
   localparam logic [7:0] CODE_PROG_CHECK = 8'hC0;
   localparam logic [7:0] CODE_RESET = 8'hFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // identifier addresses
   localparam int ID_ADDR_MAKER = 0;
   localparam int ID_ADDR_PART = 1;
   // timing: least times round up, longest round down
   localparam int STROBE_NS = 100;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_NS = 90;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROG_PULSE_NS = 10000;
   localparam int PROG_PULSE_CYC = PROG_PULSE_NS / CLK_NS;
   localparam int PROG_MAX_PULSES = 25;
   localparam int ERASE_PULSE_US = 10000;
   localparam int ERASE_PULSE_CYC = (ERASE_PULSE_US * 1000) / CLK_NS;
   localparam int ERASE_MAX_PULSES = 1000;
   localparam int VERIFY_SETTLE_NS = 6000;
   localparam int VERIFY_SETTLE_CYC = (VERIFY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int VPP_RAMP_NS = 1000;
   localparam int VPP_RAMP_CYC = (VPP_RAMP_NS + CLK_NS - 1) / CLK_NS;
   // user operations
   typedef enum logic [2:0]
   {
      OP_READ = 3'h0,
      OP_IDENT = 3'h1,
      OP_ERASE = 3'h2,
      OP_PROG = 3'h3,
      OP_ABORT = 3'h4
   } op_t;
endpackage : flash_host_pkg

// ### flash_bus_cycle.sv
// one read or write cycle on the flash parallel pins
`timescale 1ns/10ps
module flash_bus_cycle
   import flash_host_pkg::*;
#(
   parameter int AW = 18
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // request
   input wire logic start,
   input wire logic is_write,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   // pins
   output logic [AW-1:0] mem_addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_in,
   output logic ce_n,
   output logic we_n,
   output logic oe_n
);
   typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_STROBE = 2'b11,
      PH_HOLD = 2'b10} phase_t;
   localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
   localparam logic [3:0] ACCESS_LAST = 4'(ACCESS_CYC - 1);
   if (AW < 2 || AW > 32)
   begin : g_aw_check
      $error("flash_bus_cycle: AW out of range");
   end

   phase_t ph_r, ph_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic wr_r, wr_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic [7:0] dq_r, dq_nxt, rd_r, rd_nxt;
   logic ce_r, ce_nxt, we_r, we_nxt, oe_r, oe_nxt, drv_r, drv_nxt, done_r, done_nxt;

   always_comb
   begin
      ph_nxt = ph_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      dq_nxt = dq_r;
      rd_nxt = rd_r;
      ce_nxt = ce_r;
      we_nxt = we_r;
      oe_nxt = oe_r;
      drv_nxt = drv_r;
      done_nxt = 1'b0;
      unique case (ph_r)
         PH_IDLE:
            if (start)
            begin
               // address and select settle a cycle before the strobe falls
               ph_nxt = PH_SETUP;
               wr_nxt = is_write;
               addr_nxt = addr;
               dq_nxt = wdata;
               ce_nxt = 1'b0;
               drv_nxt = is_write;
            end
         PH_SETUP:
         begin
            // device latches address on the falling write strobe
            ph_nxt = PH_STROBE;
            cnt_nxt = '0;
            we_nxt = !wr_r;
            oe_nxt = wr_r;
         end
         PH_STROBE:
            if (cnt_r == (wr_r ? STROBE_LAST : ACCESS_LAST))
            begin
               // data is latched on the rising strobe, so it holds one more cycle
               ph_nxt = PH_HOLD;
               we_nxt = 1'b1;
               oe_nxt = 1'b1;
               if (!wr_r)
                  rd_nxt = dq_in;
            end
            else
               cnt_nxt = cnt_r + 4'h1;
         PH_HOLD:
         begin
            ph_nxt = PH_IDLE;
            ce_nxt = 1'b1;
            drv_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         ph_r <= PH_IDLE;
         cnt_r <= '0;
         wr_r <= 1'b0;
         addr_r <= '0;
         dq_r <= 8'h00;
         rd_r <= 8'h00;
         ce_r <= 1'b1;
         we_r <= 1'b1;
         oe_r <= 1'b1;
         drv_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         ph_r <= ph_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         dq_r <= dq_nxt;
         rd_r <= rd_nxt;
         ce_r <= ce_nxt;
         we_r <= we_nxt;
         oe_r <= oe_nxt;
         drv_r <= drv_nxt;
         done_r <= done_nxt;
      end

   assign done = done_r;
   assign rdata = rd_r;
   assign mem_addr = addr_r;
   assign dq_out = dq_r;
   assign dq_oe = drv_r;
   assign ce_n = ce_r;
   assign we_n = we_r;
   assign oe_n = oe_r;
endmodule : flash_bus_cycle

// ### flash_prog_host.sv
// host sequencer that reads, identifies, erases and programs a byte-wide flash
`timescale 1ns/10ps
// Operation
// - identifier mode ends only by new command (the model also returns to read when vpp_en falls)
// - check address presented with command write
// - rewrite erase-check command before every byte
// - failed byte: erase again, resume there
// - leave erase check with a valid command
// - host compares program-check readback with payload
// - two all-ones writes after setup abort
// - after abort, host writes a valid command
// - program any order, check each byte immediately
// - writes need strobe and select both low
module flash_prog_host
   import flash_host_pkg::*;
#(
   parameter int AW = 18,
   parameter int ERASE_CYC = ERASE_PULSE_CYC,
   parameter int ERASE_TRIES = ERASE_MAX_PULSES,
   parameter int PROG_TRIES = PROG_MAX_PULSES
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // user command port
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   output logic busy,
   output logic done,
   output logic fail,
   output logic [7:0] rd_data,
   // flash pins
   output logic [AW-1:0] mem_addr,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_in,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic vpp_en
);
   typedef enum logic [3:0]
   {
      S_IDLE = 4'b0000,
      S_VPP = 4'b0001,
      S_W1 = 4'b0011,
      S_W2 = 4'b0010,
      S_DWELL = 4'b0110,
      S_WV = 4'b0111,
      S_SETTLE = 4'b0101,
      S_RD = 4'b0100,
      S_EVAL = 4'b1100,
      S_WEXIT = 4'b1101,
      S_DONE = 4'b1111
   } state_t;

   localparam int TW = 24;
   localparam logic [TW-1:0] T_VPP = TW'(VPP_RAMP_CYC - 1);
   localparam logic [TW-1:0] T_PROG = TW'(PROG_PULSE_CYC - 1);
   localparam logic [TW-1:0] T_ERASE = TW'(ERASE_CYC - 1);
   localparam logic [TW-1:0] T_SETTLE = TW'(VERIFY_SETTLE_CYC - 1);
   localparam logic [AW-1:0] LAST_ADDR = '1;
   if (ERASE_CYC < 1 || ERASE_CYC >= (1 << TW))
   begin : g_erase_cyc_check
      $error("flash_prog_host: ERASE_CYC out of range");
   end
   if (ERASE_TRIES < 1 || ERASE_TRIES > 1023 || PROG_TRIES < 1 || PROG_TRIES > 1023)
   begin : g_tries_check
      $error("flash_prog_host: try limits out of range");
   end

   state_t st_r, st_nxt;
   op_t op_r, op_nxt;
   logic issued_r, issued_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic [9:0] tries_r, tries_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt, rd_r, rd_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, fail_r, fail_nxt, vpp_r, vpp_nxt;
   logic cyc_start, cyc_write, cyc_done;
   logic [AW-1:0] cyc_addr;
   logic [7:0] cyc_wdata, cyc_rdata;
   logic bus_state;

   flash_bus_cycle #(.AW(AW)) u_cycle (
      .core_clk(core_clk),
      .nrst(nrst),
      .start(cyc_start),
      .is_write(cyc_write),
      .addr(cyc_addr),
      .wdata(cyc_wdata),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .mem_addr(mem_addr),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .dq_in(dq_in),
      .ce_n(ce_n),
      .we_n(we_n),
      .oe_n(oe_n)
   );

   // what each bus state puts on the pins
   always_comb
   begin
      cyc_write = 1'b1;
      cyc_addr = addr_r;
      cyc_wdata = CODE_READ;
      unique case (st_r)
         S_W1:
            unique case (op_r)
               OP_READ: cyc_wdata = CODE_READ;
               OP_IDENT: cyc_wdata = CODE_IDENT;
               OP_ERASE: cyc_wdata = CODE_ERASE;
               OP_PROG: cyc_wdata = CODE_PROG_SETUP;
               OP_ABORT: cyc_wdata = CODE_RESET;
               default: cyc_wdata = CODE_READ;
            endcase
         S_W2:
            unique case (op_r)
               OP_ERASE: cyc_wdata = CODE_ERASE;
               OP_PROG: cyc_wdata = data_r;
               default: cyc_wdata = CODE_RESET;
            endcase
         // erase check carries the byte address; program check keeps the old one
         S_WV: cyc_wdata = (op_r == OP_ERASE) ? CODE_ERASE_CHECK
            : CODE_PROG_CHECK;
         S_RD: cyc_write = 1'b0;
         S_WEXIT: cyc_wdata = CODE_READ;
         default: cyc_write = 1'b1;
      endcase
   end

   assign bus_state = (st_r == S_W1) || (st_r == S_W2) || (st_r == S_WV) ||
      (st_r == S_RD) || (st_r == S_WEXIT);
   assign cyc_start = bus_state && !issued_r;

   always_comb
   begin
      st_nxt = st_r;
      op_nxt = op_r;
      issued_nxt = issued_r;
      tmr_nxt = tmr_r;
      tries_nxt = tries_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      rd_nxt = rd_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      fail_nxt = fail_r;
      vpp_nxt = vpp_r;
      if (cyc_start)
         issued_nxt = 1'b1;
      if (bus_state && cyc_done)
         issued_nxt = 1'b0;
      unique case (st_r)
         S_IDLE:
            if (cmd_valid)
            begin
               // undecoded codes take the abort path, which alters nothing
               op_nxt = (cmd_op > 3'h4) ? OP_ABORT : op_t'(cmd_op);
               addr_nxt = (op_t'(cmd_op) == OP_ERASE) ? '0 : cmd_addr;
               data_nxt = cmd_data;
               tries_nxt = '0;
               tmr_nxt = '0;
               busy_nxt = 1'b1;
               fail_nxt = 1'b0;
               // plain array reads need no programming supply
               if (op_t'(cmd_op) == OP_READ)
                  st_nxt = S_W1;
               else
               begin
                  vpp_nxt = 1'b1;
                  st_nxt = S_VPP;
               end
            end
         S_VPP:
            // supply must settle first, else the latch sits at read
            if (tmr_r == T_VPP)
               st_nxt = S_W1;
            else
               tmr_nxt = tmr_r + 1'b1;
         S_W1:
            if (cyc_done)
               st_nxt = (op_r == OP_READ || op_r == OP_IDENT) ? S_RD : S_W2;
         S_W2:
            if (cyc_done)
            begin
               tmr_nxt = '0;
               st_nxt = (op_r == OP_ABORT) ? S_WEXIT : S_DWELL;
            end
         S_DWELL:
            // operation runs from this rising strobe to the check write
            if (tmr_r == ((op_r == OP_ERASE) ? T_ERASE : T_PROG))
               st_nxt = S_WV;
            else
               tmr_nxt = tmr_r + 1'b1;
         S_WV:
            if (cyc_done)
            begin
               tmr_nxt = '0;
               st_nxt = S_SETTLE;
            end
         S_SETTLE:
            if (tmr_r == T_SETTLE)
               st_nxt = S_RD;
            else
               tmr_nxt = tmr_r + 1'b1;
         S_RD:
            if (cyc_done)
            begin
               rd_nxt = cyc_rdata;
               st_nxt = (op_r == OP_ERASE || op_r == OP_PROG) ? S_EVAL : S_WEXIT;
            end
         S_EVAL:
            if (op_r == OP_PROG)
            begin
               if (rd_r == data_r)
                  st_nxt = S_WEXIT;
               else if (tries_r == 10'(PROG_TRIES - 1))
               begin
                  fail_nxt = 1'b1;
                  st_nxt = S_WEXIT;
               end
               else
               begin
                  tries_nxt = tries_r + 10'h001;
                  st_nxt = S_W1;
               end
            end
            else if (rd_r == ERASED_BYTE)
            begin
               if (addr_r == LAST_ADDR)
                  st_nxt = S_WEXIT;
               else
               begin
                  addr_nxt = addr_r + 1'b1;
                  st_nxt = S_WV;
               end
            end
            else if (tries_r == 10'(ERASE_TRIES - 1))
            begin
               fail_nxt = 1'b1;
               st_nxt = S_WEXIT;
            end
            else
            begin
               // address is kept, so checking resumes at this byte
               tries_nxt = tries_r + 10'h001;
               st_nxt = S_W1;
            end
         S_WEXIT:
            if (cyc_done)
               st_nxt = S_DONE;
         S_DONE:
         begin
            vpp_nxt = 1'b0;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end
         default:
            st_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         st_r <= S_IDLE;
         op_r <= OP_READ;
         issued_r <= 1'b0;
         tmr_r <= '0;
         tries_r <= '0;
         addr_r <= '0;
         data_r <= 8'h00;
         rd_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         vpp_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         issued_r <= issued_nxt;
         tmr_r <= tmr_nxt;
         tries_r <= tries_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         rd_r <= rd_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         fail_r <= fail_nxt;
         vpp_r <= vpp_nxt;
      end

   assign busy = busy_r;
   assign done = done_r;
   assign fail = fail_r;
   assign rd_data = rd_r;
   assign vpp_en = vpp_r;
endmodule : flash_prog_host

// ### flash_host_properties.sv
// concurrent checks on the flash host's command port and pins
`timescale 1ns/10ps
module flash_host_properties
   import flash_host_pkg::*;
#(
   parameter int AW = 18
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // command port
   input wire logic cmd_valid,
   input wire logic busy,
   input wire logic done,
   // pins
   input wire logic [AW-1:0] mem_addr,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic vpp_en
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // a strobe stays low two cycles, counting the cycle it fell in
   sequence strobe_s(logic s);
      !s [*2] ##1 s;
   endsequence
   we_width_a: assert property ($fell(we_n) |-> strobe_s(we_n)) else $error("write strobe width");
   oe_width_a: assert property ($fell(oe_n) |-> strobe_s(oe_n)) else $error("read strobe width");
   strobe_select_a: assert property (!we_n || !oe_n |-> !ce_n) else $error("strobe without select");
   write_drive_a: assert property (!we_n |-> dq_oe && oe_n) else $error("write not driven");
   read_release_a: assert property (!oe_n |-> !dq_oe) else $error("bus fight on read");
   cycle_hold_a: assert property (!ce_n && $past(!ce_n) |-> $stable(mem_addr) && $stable(dq_out))
      else $error("address or data moved");
   supply_gate_a: assert property (!we_n && (dq_out == CODE_ERASE || dq_out == CODE_PROG_SETUP)
      |-> vpp_en) else $error("setup without supply");
   accept_busy_a: assert property (cmd_valid && !busy |=> busy) else $error("request not taken");
   done_pulse_a: assert property (done |-> !busy ##1 !done) else $error("done not one cycle");
   idle_quiet_a: assert property (!busy && !$past(busy) |-> ce_n && we_n) else $error("bus active idle");
endmodule : flash_host_properties

bind flash_prog_host flash_host_properties #(.AW(AW)) chk (.core_clk(core_clk), .nrst(nrst),
   .cmd_valid(cmd_valid), .busy(busy), .done(done), .mem_addr(mem_addr), .dq_out(dq_out),
   .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .vpp_en(vpp_en));

// ### flash_device_model.sv
// behavioural byte-wide flash: command latch, array, margin reads
`timescale 1ns/10ps
module flash_device_model
   import flash_host_pkg::*;
#(
   parameter int AW = 4,
   // identity values are arbitrary
   parameter logic [7:0] MAKER_CODE = 8'h5A,
   parameter logic [7:0] PART_CODE = 8'h3C
)
(
   // pins
   input wire logic [AW-1:0] mem_addr,
   input wire logic [7:0] dq_out,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic vpp_en,
   output logic [7:0] dq_in,
   // fault knobs
   input wire logic stub_en,
   input wire logic [AW-1:0] stub_a,
   input wire logic prog_stuck
);
   typedef enum {RD, ID, ESET, ERUN, ECHK, PSET, PWR, PCHK, RST1} mode_t;
   mode_t mode = RD;
   logic [7:0] mem [2**AW];
   logic [AW-1:0] cur_a, erase_check_address, program_target_address;
   logic [7:0] program_payload, rv, d;
   int erase_n = 0;
   initial foreach (mem[i]) mem[i] = 8'h00;
   always @(negedge vpp_en) mode = RD;
   always @(negedge we_n) if (!ce_n) cur_a = mem_addr;
   always @(posedge we_n)
   begin
      d = dq_out;
      if (!ce_n && vpp_en)
      begin
         if (mode == ERUN)
         begin
            foreach (mem[i]) mem[i] = (stub_en && i == stub_a && erase_n == 0) ? 8'h00 : 8'hFF;
            erase_n++;
         end
         if (mode == PWR && !prog_stuck)
            mem[program_target_address] = mem[program_target_address] & program_payload;
         if (mode inside {PSET, ESET} && d == CODE_RESET) mode = RST1;
         else if (mode == RST1 && d == CODE_RESET) mode = RD;
         else if (mode == ESET && d == CODE_ERASE) mode = ERUN;
         else if (mode == PSET)
         begin
            program_target_address = cur_a;
            program_payload = d;
            mode = PWR;
         end
         else
            case (d)
               CODE_IDENT: mode = ID;
               CODE_ERASE: mode = ESET;
               CODE_ERASE_CHECK:
               begin
                  erase_check_address = cur_a;
                  mode = ECHK;
               end
               CODE_PROG_SETUP: mode = PSET;
               CODE_PROG_CHECK: mode = PCHK;
               default: mode = RD;
            endcase
      end
   end
   always_comb
   begin
      case (mode)
         ID: rv = (mem_addr == 0) ? MAKER_CODE : PART_CODE;
         ECHK: rv = mem[erase_check_address];
         PCHK: rv = mem[program_target_address];
         default: rv = mem[mem_addr];
      endcase
   end
   // undriven bus shows the inverse so a late sample cannot pass by luck
   assign dq_in = (!ce_n && !oe_n) ? rv : ~rv;
endmodule : flash_device_model

// ### tb.sv
// self-checking bench for the flash programming host
`timescale 1ns/10ps
module tb
   import flash_host_pkg::*;
;
   localparam int AW = 4;
   typedef struct packed {logic [7:0] data; logic chk; logic fail;} note_t;
   logic core_clk = 0, nrst = 0, cmd_valid = 0, stub_en = 0, prog_stuck = 0;
   logic [2:0] cmd_op = 0;
   logic [AW-1:0] cmd_addr = 0, stub_a = 0;
   logic [7:0] cmd_data = 0;
   logic busy, done, fail, dq_oe, ce_n, we_n, oe_n, vpp_en;
   logic [7:0] rd_data, dq_out, dq_in;
   logic [AW-1:0] mem_addr;
   logic [AW-1:0] prog_at [4];
   logic [7:0] pv [4];
   note_t notes [$];
   int miscompares = 0, comparisons = 0;
   always #(CLK_NS / 2) core_clk = ~core_clk;
   flash_prog_host #(.AW(AW), .ERASE_CYC(50)) dut (.core_clk(core_clk), .nrst(nrst),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .busy(busy), .done(done), .fail(fail), .rd_data(rd_data), .mem_addr(mem_addr),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .vpp_en(vpp_en));
   flash_device_model #(.AW(AW)) m (.mem_addr(mem_addr), .dq_out(dq_out), .ce_n(ce_n),
      .we_n(we_n), .oe_n(oe_n), .vpp_en(vpp_en), .dq_in(dq_in), .stub_en(stub_en),
      .stub_a(stub_a), .prog_stuck(prog_stuck));
   task summarize;
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // one operation; entered and left at a falling edge
   task run(input logic [2:0] op, input logic [AW-1:0] a, input logic [7:0] d,
      input logic [7:0] ed, input logic ec, input logic ef);
      int i;
      note_t n;
      n.data = ed;
      n.chk = ec;
      n.fail = ef;
      notes.push_back(n);
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1;
      @(negedge core_clk);
      cmd_valid = 0;
      for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge core_clk);
      if (i == 20000)
      begin
         miscompares++;
         summarize();
      end
   endtask : run
   // looked at on the falling edge, where the registered outputs have settled
   always @(negedge core_clk)
   begin
      note_t n;
      if (done === 1'b1)
      begin
         if (notes.size() == 0)
            check(8'h00, 8'h01, "unexpected done");
         else
         begin
            n = notes.pop_front();
            if (n.chk) check(rd_data, n.data, "rd_data");
            check({7'h00, fail}, {7'h00, n.fail}, "fail");
         end
      end
   end
   initial
   begin
      logic [AW-1:0] r;
      void'($urandom(32'h61154472));
      repeat (20) @(negedge core_clk);
      nrst = 1;
      run(OP_IDENT, 0, 0, m.MAKER_CODE, 1, 0);
      run(OP_IDENT, 1, 0, m.PART_CODE, 1, 0);
      r = AW'($urandom % 16);
      run(OP_READ, r, 0, 8'h00, 1, 0);
      run(OP_ABORT, 0, 0, 0, 0, 0);
      run(OP_READ, r, 0, 8'h00, 1, 0);
      stub_en = 1;
      stub_a = 5;
      run(OP_ERASE, 0, 0, ERASED_BYTE, 1, 0);
      check(8'(m.erase_n), 8'h02, "erase count");
      run(OP_READ, 5, 0, ERASED_BYTE, 1, 0);
      run(OP_READ, 15, 0, ERASED_BYTE, 1, 0);
      for (int i = 0; i < 4; i++)
      begin
         prog_at[i] = AW'(12 - i * 4 + $urandom % 4);
         pv[i] = 8'($urandom) | 8'h01;
         run(OP_PROG, prog_at[i], pv[i], pv[i], 1, 0);
      end
      for (int i = 0; i < 4; i++) run(OP_READ, prog_at[i], 0, pv[i], 1, 0);
      prog_stuck = 1;
      run(OP_PROG, prog_at[0], 8'h00, pv[0], 1, 1);
      prog_stuck = 0;
      run(3'h7, 0, 0, 0, 0, 0);
      run(OP_READ, prog_at[1], 0, pv[1], 1, 0);
      repeat (3) @(negedge core_clk);
      summarize();
   end
endmodule : tb
